// ### rx_event_regs.svh
`ifndef RX_EVENT_REGS_SVH
`define RX_EVENT_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_ALARM 9'h090
`define IDX_FRAMING 9'h091
`define IDX_CODE 9'h092
`define IDX_STORE 9'h093
`define IDX_CTRL 9'h0F0
`define IDX_MASK 9'h0F1
`define IDX_STATE 9'h0F2
`define PORT_STRIDE 16'h0200
`define NUM_PORTS 4

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTRL_E1_BIT 0
`define CTRL_SHORT_BIT 1
`define CTRL_MANUAL_BIT 2
`define CTRL_CRC4_BIT 3
`define CTRL_RESET 8'h00
`define MASK_RESET 32'h00000000
`define LATCH_RESET 8'h00

// ----------------------------------------------------------------
// Detector thresholds
// ----------------------------------------------------------------
`define SIG_LOSS_ZEROS 192
`define ZERO_RUN_SHORT 8
`define ZERO_RUN_LONG 16
`define SEF_WINDOW 6
`define CRC_BLOCK 1000
`define CRC_BAD 915
`define MF_ERRS 2
`define FAS_ERRS 3

// ----------------------------------------------------------------
// Timing: line rates, intervals and derived counts
// ----------------------------------------------------------------
`define PCLK_NS 100
`define T1_RATE_HZ 1544000
`define E1_RATE_HZ 2048000
`define SHORT_T1_US 42000
`define SHORT_E1_US 62500
`define MF_ARB_US 2000
`define CH_BITS 8
`define SHORT_T1_EDGES (`T1_RATE_HZ / 1000 * `SHORT_T1_US / 1000)
`define SHORT_E1_EDGES (`E1_RATE_HZ / 1000 * `SHORT_E1_US / 1000)
`define MF_ARB_EDGES (`E1_RATE_HZ / 1000 * `MF_ARB_US / 1000)
`define CH_NS_T1 (`CH_BITS * 1000000 / (`T1_RATE_HZ / 1000))
`define CH_NS_E1 (`CH_BITS * 1000000 / (`E1_RATE_HZ / 1000))
`define CH_CYC_T1 ((`CH_NS_T1 + `PCLK_NS - 1) / `PCLK_NS)
`define CH_CYC_E1 ((`CH_NS_E1 + `PCLK_NS - 1) / `PCLK_NS)

`endif

// ### rx_event_pkg.sv
package rx_event_pkg;

   // Per-port inputs from the receive framer and line decoder
   typedef struct packed {
      logic rx_line_clock;
      logic bit_valid;
      logic bit_value;
      logic remote_alarm_cond;
      logic all_ones_alarm_cond;
      logic frame_loss_cond;
      logic alignment_change;
      logic fbit_valid;
      logic fbit_err;
      logic b8zs_codeword;
      logic crc_word_valid;
      logic crc_word_err;
      logic mf_word_valid;
      logic mf_word_err;
      logic fas_word_valid;
      logic fas_word_err;
      logic sig_all_ones;
      logic sig_all_zeros;
      logic crc_mf_boundary;
      logic align_frame;
      logic spare_code_cond;
      logic loop_down_cond;
      logic loop_up_cond;
      logic access_link_id_cond;
      logic ts16_bit6_valid;
      logic ts16_bit6;
      logic estore_full;
      logic estore_empty;
      logic sig_change;
      logic mf_boundary;
   } port_in_s;

   typedef logic [7:0] byte_t;

endpackage : rx_event_pkg

// ### rx_event_latches.sv
`timescale 1ns/1ps
`include "rx_event_regs.svh"

module rx_event_latches
   import rx_event_pkg::*;
#(
   parameter int unsigned SEC_T1 = `T1_RATE_HZ,
   parameter int unsigned SEC_E1 = `E1_RATE_HZ,
   parameter int unsigned SHORT_T1 = `SHORT_T1_EDGES,
   parameter int unsigned SHORT_E1 = `SHORT_E1_EDGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input port_in_s port_in [`NUM_PORTS],
   output logic int_n
);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic [13:0] idx;
   logic [1:0] sel_port;
   logic [8:0] loc;
   logic mapped;
   logic setup_rd;
   logic access_rd;
   logic access_wr;
   logic [31:0] rd_mux;
   logic [31:0] prdata_q;
   logic [2:0] rd_reg_q;
   logic [1:0] rd_port_q;
   logic rd_latch_q;

   wire [`NUM_PORTS-1:0][3:0][7:0] lat_all;
   wire [`NUM_PORTS-1:0][7:0] ctrl_all;
   wire [`NUM_PORTS-1:0][31:0] mask_all;
   wire [`NUM_PORTS-1:0][15:0] state_all;
   wire [`NUM_PORTS-1:0] irq_all;

   // Port in index bits 10:9 follows from the 200h stride
   assign idx = paddr[15:2];
   assign sel_port = idx[10:9];
   assign loc = idx[8:0];
   assign mapped = (paddr[1:0] == 2'h0) && (idx[13:11] == 3'h0) &&
      ((loc >= `IDX_ALARM && loc <= `IDX_STORE) || loc == `IDX_CTRL ||
       loc == `IDX_MASK || loc == `IDX_STATE);
   assign setup_rd = psel && !penable && !pwrite;
   assign access_rd = psel && penable && !pwrite && mapped;
   assign access_wr = psel && penable && pwrite && mapped;

   // Zero-wait slave; data was captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;

   // Read multiplexer
   always_comb begin
      rd_mux = 32'h00000000;
      if (loc >= `IDX_ALARM && loc <= `IDX_STORE) begin
         rd_mux[7:0] = lat_all[sel_port][loc[1:0]];
      end else if (loc == `IDX_CTRL) begin
         rd_mux[7:0] = ctrl_all[sel_port];
      end else if (loc == `IDX_MASK) begin
         rd_mux = mask_all[sel_port];
      end else if (loc == `IDX_STATE) begin
         rd_mux[15:0] = state_all[sel_port];
      end
      if (!mapped) begin
         rd_mux = 32'h00000000;
      end
   end

   // Capture read data at setup so it comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         rd_reg_q <= 3'h0;
         rd_port_q <= 2'h0;
         rd_latch_q <= 1'b0;
      end else if (setup_rd) begin
         prdata_q <= rd_mux;
         rd_port_q <= sel_port;
         rd_reg_q <= {1'b0, loc[1:0]};
         rd_latch_q <= mapped && loc >= `IDX_ALARM && loc <= `IDX_STORE;
      end
   end

   // Interrupt output, active low
   assign int_n = ~(|irq_all);

   // ----------------------------------------------------------------
   // Per-port logic
   // ----------------------------------------------------------------
   for (genvar g = 0; g < `NUM_PORTS; g++) begin : g_port
      port_in_s pi;
      byte_t ctrl_q;
      logic [31:0] mask_q;
      byte_t lat_q [4];
      byte_t set_v [4];
      byte_t clr_v [4];
      byte_t elig [4];
      logic e1;
      logic rxclk_q;
      logic rx_edge;
      logic manual_pulse;
      logic [7:0] zero_q;
      logic [5:0] sef_q;
      logic [9:0] crc_words_q;
      logic [9:0] crc_bad_q;
      logic [1:0] mf_err_q;
      logic [1:0] fas_err_q;
      logic [1:0] dmf_q;
      logic [6:0] silent_q;
      logic [20:0] sec_q;
      logic [20:0] tmr_q;
      logic [12:0] arb_q;
      logic sig_loss;
      logic clk_loss;
      logic dmf_cond;
      logic [9:0] cond;
      logic [9:0] cond_q;
      logic [9:0] rise;
      logic [9:0] fall;
      logic z8;
      logic z16;
      logic severe_framing_err_evt;
      logic crc_rs;
      logic mf_rs;
      logic fas_rs;
      logic sec_evt;
      logic tmr_evt;
      logic arb_evt;
      logic [6:0] silent_lim;
      logic [20:0] sec_lim;
      logic [20:0] tmr_lim;
      logic wr_here;

      assign pi = port_in[g];
      assign e1 = ctrl_q[`CTRL_E1_BIT];
      assign rx_edge = pi.rx_line_clock && !rxclk_q;
      assign wr_here = access_wr && sel_port == 2'(g);
      assign manual_pulse = wr_here && loc == `IDX_CTRL &&
         pwdata[`CTRL_MANUAL_BIT];

      // Control and mask registers; manual latch bit is self-clearing
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
            mask_q <= `MASK_RESET;
         end else if (wr_here && loc == `IDX_CTRL) begin
            ctrl_q <= pwdata[7:0] & ~(8'h01 << `CTRL_MANUAL_BIT);
         end else if (wr_here && loc == `IDX_MASK) begin
            mask_q <= pwdata;
         end
      end

      // Zero run on the line: signal loss and run-length events
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            zero_q <= 8'h00;
         end else if (pi.bit_valid) begin
            if (pi.bit_value) begin
               zero_q <= 8'h00;
            end else if (zero_q != 8'hFF) begin
               zero_q <= zero_q + 8'h01;
            end
         end
      end
      assign sig_loss = zero_q >= 8'(`SIG_LOSS_ZEROS);
      // One event per run however long it grows
      assign z8 = pi.bit_valid && !pi.bit_value &&
         zero_q == 8'(`ZERO_RUN_SHORT - 1);
      assign z16 = pi.bit_valid && !pi.bit_value &&
         zero_q == 8'(`ZERO_RUN_LONG - 1);

      // Sliding window over the last framing bits
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sef_q <= 6'h00;
         end else if (pi.fbit_valid) begin
            sef_q <= {sef_q[4:0], pi.fbit_err};
         end
      end
      // A new error with another among the previous five: 2 of 6
      assign severe_framing_err_evt = pi.fbit_valid && pi.fbit_err &&
         |sef_q[`SEF_WINDOW-2:0];

      // CRC-4 block: count words and errored words per block
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            crc_words_q <= 10'h000;
            crc_bad_q <= 10'h000;
         end else if (pi.crc_word_valid) begin
            if (crc_words_q == 10'(`CRC_BLOCK - 1)) begin
               crc_words_q <= 10'h000;
               crc_bad_q <= 10'h000;
            end else begin
               crc_words_q <= crc_words_q + 10'h001;
               crc_bad_q <= crc_bad_q + {9'h000, pi.crc_word_err};
            end
         end
      end
      assign crc_rs = pi.crc_word_valid &&
         crc_words_q == 10'(`CRC_BLOCK - 1) &&
         (crc_bad_q + {9'h000, pi.crc_word_err}) >= 10'(`CRC_BAD);

      // Consecutive errored alignment words
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mf_err_q <= 2'h0;
         end else if (pi.mf_word_valid) begin
            mf_err_q <= !pi.mf_word_err ? 2'h0 :
               (mf_rs ? 2'h0 : mf_err_q + 2'h1);
         end
      end
      assign mf_rs = pi.mf_word_valid && pi.mf_word_err &&
         mf_err_q == 2'(`MF_ERRS - 1);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fas_err_q <= 2'h0;
         end else if (pi.fas_word_valid) begin
            fas_err_q <= !pi.fas_word_err ? 2'h0 :
               (fas_rs ? 2'h0 : fas_err_q + 2'h1);
         end
      end
      assign fas_rs = pi.fas_word_valid && pi.fas_word_err &&
         fas_err_q == 2'(`FAS_ERRS - 1);

      // Distant alarm bit of two consecutive multiframes
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dmf_q <= 2'h0;
         end else if (pi.ts16_bit6_valid) begin
            dmf_q <= {dmf_q[0], pi.ts16_bit6};
         end
      end
      assign dmf_cond = &dmf_q;

      // Receive clock watchdog counted in pclk cycles
      assign silent_lim = e1 ? 7'(`CH_CYC_E1) : 7'(`CH_CYC_T1);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rxclk_q <= 1'b0;
            silent_q <= 7'h00;
         end else begin
            rxclk_q <= pi.rx_line_clock;
            if (pi.rx_line_clock != rxclk_q) begin
               silent_q <= 7'h00;
            end else if (silent_q != 7'h7F) begin
               silent_q <= silent_q + 7'h01;
            end
         end
      end
      assign clk_loss = silent_q >= silent_lim;

      // Interval timers on receive clock edges; they stop with it
      assign sec_lim = e1 ? 21'(SEC_E1 - 1) : 21'(SEC_T1 - 1);
      assign tmr_lim = !ctrl_q[`CTRL_SHORT_BIT] ? sec_lim :
         (e1 ? 21'(SHORT_E1 - 1) : 21'(SHORT_T1 - 1));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sec_q <= 21'h000000;
            tmr_q <= 21'h000000;
            arb_q <= 13'h0000;
         end else if (rx_edge) begin
            sec_q <= sec_evt ? 21'h000000 : sec_q + 21'h000001;
            tmr_q <= (tmr_q >= tmr_lim) ? 21'h000000 : tmr_q + 21'h000001;
            arb_q <= arb_evt ? 13'h0000 : arb_q + 13'h0001;
         end
      end
      assign sec_evt = rx_edge && sec_q >= sec_lim;
      assign tmr_evt = (rx_edge && tmr_q >= tmr_lim) || manual_pulse;
      assign arb_evt = rx_edge && arb_q == 13'(`MF_ARB_EDGES - 1);

      // Condition edge detection
      assign cond = {pi.remote_alarm_cond, pi.all_ones_alarm_cond, sig_loss,
         pi.frame_loss_cond, clk_loss, pi.spare_code_cond,
         pi.loop_down_cond, pi.loop_up_cond, pi.access_link_id_cond,
         dmf_cond};
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cond_q <= 10'h000;
         end else begin
            cond_q <= cond;
         end
      end
      assign rise = cond & ~cond_q;
      assign fall = ~cond & cond_q;

      // Event sets per register
      always_comb begin
         set_v[0] = {fall[9:6], rise[9:6]};
         if (e1) begin
            set_v[1] = {1'b0, crc_rs, mf_rs, fas_rs, pi.sig_all_ones,
               pi.sig_all_zeros,
               ctrl_q[`CTRL_CRC4_BIT] ? pi.crc_mf_boundary : arb_evt,
               pi.align_frame};
            set_v[2] = {fall[5], 1'b0, fall[1], fall[0], rise[5], 1'b0,
               rise[1], rise[0]};
         end else begin
            set_v[1] = {2'b00, pi.alignment_change, z8, z16, severe_framing_err_evt,
               pi.b8zs_codeword, pi.fbit_valid && pi.fbit_err};
            set_v[2] = {fall[5:2], rise[5:2]};
         end
         set_v[3] = {pi.estore_full, pi.estore_empty,
            pi.estore_full || pi.estore_empty, 1'b0, pi.sig_change,
            sec_evt, tmr_evt, pi.mf_boundary};
      end

      // Interrupt eligibility per register and mode
      always_comb begin
         elig[0] = 8'hFF;
         elig[1] = e1 ? 8'h0F : 8'h00;
         elig[2] = 8'hFF;
         elig[3] = 8'hFF;
      end

      // Latches: only the bits actually returned are cleared, so an
      // event arriving during the read survives
      for (genvar r = 0; r < 4; r++) begin : g_reg
         assign clr_v[r] = (access_rd && rd_latch_q && rd_port_q == 2'(g) &&
            rd_reg_q[1:0] == 2'(r)) ? prdata_q[7:0] : 8'h00;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lat_q[r] <= `LATCH_RESET;
            end else begin
               lat_q[r] <= (lat_q[r] & ~clr_v[r]) | set_v[r];
            end
         end
         assign lat_all[g][r] = lat_q[r];
      end

      assign ctrl_all[g] = ctrl_q;
      assign mask_all[g] = mask_q;
      assign state_all[g] = {6'h00, cond};
      assign irq_all[g] =
         |({lat_q[3], lat_q[2], lat_q[1], lat_q[0]} & mask_q &
           {elig[3], elig[2], elig[1], elig[0]});
   end

endmodule : rx_event_latches

// ### rx_event_monitor.sv
`timescale 1ns/1ps
`include "rx_event_regs.svh"

module rx_event_monitor
   import rx_event_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input port_in_s port_in [`NUM_PORTS],
   input wire logic int_n
);
   // ----------------
   // Shadow state
   // ----------------
   logic [31:0] mask_q [`NUM_PORTS];
   logic [`NUM_PORTS-1:0] e1_q;
   logic [7:0] zeros_q;
   logic hit;
   logic m_zero;
   logic m_fr;
   logic m_hi;

   // Refused word addresses must not touch the shadow
   assign hit = psel && penable && pwrite && pready && paddr[1:0] == 2'h0
      && paddr[15:13] == 3'h0;

   // Mask and mode copies, updated on the same edge as the design
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= '{default: 32'h0};
         e1_q <= '0;
      end else if (hit && paddr[10:2] == `IDX_MASK) begin
         mask_q[paddr[12:11]] <= pwdata;
      end else if (hit && paddr[10:2] == `IDX_CTRL) begin
         e1_q[paddr[12:11]] <= pwdata[`CTRL_E1_BIT];
      end
   end

   // Zero run on port 0; saturates so a long run never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zeros_q <= 8'h00;
      end else if (port_in[0].bit_valid) begin
         zeros_q <= port_in[0].bit_value ? 8'h00
            : zeros_q + {7'h00, zeros_q != 8'hFF};
      end
   end

   // Mask classes across all ports
   always_comb begin
      m_zero = 1'b1;
      m_fr = 1'b1;
      m_hi = 1'b1;
      for (int p = 0; p < `NUM_PORTS; p++) begin
         m_zero &= mask_q[p] == 32'h0;
         m_fr &= (mask_q[p] & 32'hFFFF00FF) == 32'h0;
         m_hi &= (mask_q[p] & 32'hFFFF0FFF) == 32'h0;
      end
   end

   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_int_low;
      ##[1:3] !int_n;
   endsequence

   AST_MASKED_QUIET: assert property (m_zero |-> int_n)
      else $error("int_n low with all masks off");
   AST_T1_FRAMING_SILENT: assert property (m_fr && ~|e1_q |-> int_n)
      else $error("T1 framing register raised int_n");
   AST_E1_UPPER_SILENT: assert property (m_hi |-> int_n)
      else $error("framing bits 7..4 raised int_n");
   AST_ALARM_RAISES_INT: assert property (
      $rose(port_in[0].frame_loss_cond) && mask_q[0][0] |-> s_int_low)
      else $error("frame loss detect gave no interrupt");
   AST_SIG_LOSS_INT: assert property (
      port_in[0].bit_valid && !port_in[0].bit_value && zeros_q == 8'hBF
      && mask_q[0][1] |-> s_int_low)
      else $error("signal loss not flagged at zero 192");
   AST_STORE_FULL_INT: assert property (
      port_in[0].estore_full && mask_q[0][31] |-> s_int_low)
      else $error("store full event gave no interrupt");
   AST_LOOP_UP_INT: assert property (
      $rose(port_in[0].loop_up_cond) && !e1_q[0] && mask_q[0][16]
      |-> s_int_low)
      else $error("loop up detect gave no interrupt");
   AST_ALIGN_FRAME_INT: assert property (
      port_in[0].align_frame && e1_q[0] && mask_q[0][8] |-> s_int_low)
      else $error("align frame event gave no interrupt");

endmodule : rx_event_monitor

bind rx_event_latches rx_event_monitor i_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .port_in(port_in), .int_n(int_n)
);

// ### rx_line_model.sv
`timescale 1ns/1ps
`include "rx_event_regs.svh"

module rx_line_model
   import rx_event_pkg::*;
(
   input wire logic pclk,
   output port_in_s port_in [`NUM_PORTS]
);
   // ----------------
   // Framer outputs
   // ----------------
   port_in_s lvl_q [`NUM_PORTS] = '{default: '0};
   port_in_s pls_q [`NUM_PORTS] = '{default: '0};
   logic [`NUM_PORTS-1:0] run_q = '1;
   logic [`NUM_PORTS-1:0] ck_q = '0;
   logic [1:0] div_q = 2'h0;

   // Line clock at pclk/8, far below the pclk/2 ceiling
   always @(posedge pclk) begin
      div_q <= div_q + 2'h1;
      for (int p = 0; p < `NUM_PORTS; p++) begin
         if (div_q == 2'h3 && run_q[p]) ck_q[p] <= !ck_q[p];
      end
   end

   // Levels and one-cycle strobes merged per port
   always_comb begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
         port_in[p] = lvl_q[p] | pls_q[p];
         port_in[p].rx_line_clock = ck_q[p];
      end
   end

   task automatic pulse(input int p, input port_in_s m);
      @(posedge pclk);
      pls_q[p] <= m;
      @(posedge pclk);
      pls_q[p] <= '0;
   endtask : pulse

   task automatic set_lvl(input int p, input port_in_s m);
      @(posedge pclk);
      lvl_q[p] <= m;
   endtask : set_lvl

   task automatic send_bits(input int p, input int n, input logic v);
      repeat (n) pulse(p, '{bit_valid: 1'b1, bit_value: v, default: 1'b0});
   endtask : send_bits

   task automatic clock_run(input int p, input logic on);
      @(posedge pclk);
      run_q[p] <= on;
   endtask : clock_run

endmodule : rx_line_model

// ### receive_alarm_event_latches_test.sv
`timescale 1ns/1ps
`include "rx_event_regs.svh"

module receive_alarm_event_latches_test
   import rx_event_pkg::*;
;
   // ----------------
   // Signals
   // ----------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic pready;
   logic pslverr;
   logic int_n;
   logic rerr;
   port_in_s port_in [`NUM_PORTS];
   int n_errors = 0;
   int n_tests = 0;

   // 10 MHz bus clock
   always #50 pclk = !pclk;

   rx_event_latches i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_in(port_in), .int_n(int_n)
   );
   rx_line_model i_line (.pclk(pclk), .port_in(port_in));

   // ----------------
   // Bus and check tasks
   // ----------------
   // Request held until pready is seen high; no latency assumed
   task automatic apb(input logic wr, input int p, input logic [8:0] idx,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= 16'(4 * (idx + `PORT_STRIDE * p));
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Four edges let an edge-detected condition reach its latch
   task automatic rd_chk(input int p, input logic [8:0] idx, input byte_t e);
      repeat (4) @(posedge pclk);
      apb(1'b0, p, idx, 32'h0);
      chk(rdat, {24'h0, e});
   endtask : rd_chk

   task automatic chk_int(input logic e);
      repeat (4) @(posedge pclk);
      chk({31'h0, int_n}, {31'h0, e});
   endtask : chk_int

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   // ----------------
   // Tests
   // ----------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int p = 0; p < `NUM_PORTS; p++) begin
         for (int r = 0; r < 4; r++) rd_chk(p, `IDX_ALARM + 9'(r), 8'h00);
      end
      apb(1'b0, 0, 9'h095, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      i_line.pulse(2, '{estore_empty: 1'b1, default: 1'b0});
      rd_chk(2, `IDX_STORE, 8'h60);
      rd_chk(0, `IDX_STORE, 8'h00);
      $display("test registers finished");
      apb(1'b1, 0, `IDX_MASK, 32'h0000FF00);
      i_line.send_bits(0, 191, 1'b0);
      rd_chk(0, `IDX_ALARM, 8'h00);
      rd_chk(0, `IDX_FRAMING, 8'h18);
      i_line.pulse(0, '{alignment_change: 1'b1, default: 1'b0});
      i_line.pulse(0, '{b8zs_codeword: 1'b1, default: 1'b0});
      rd_chk(0, `IDX_FRAMING, 8'h22);
      i_line.pulse(0, '{fbit_valid: 1'b1, fbit_err: 1'b1, default: 1'b0});
      i_line.pulse(0, '{fbit_valid: 1'b1, default: 1'b0});
      i_line.pulse(0, '{fbit_valid: 1'b1, fbit_err: 1'b1, default: 1'b0});
      chk_int(1'b1);
      rd_chk(0, `IDX_FRAMING, 8'h05);
      $display("test t1 framing finished");
      apb(1'b1, 0, `IDX_MASK, 32'h800100FF);
      i_line.send_bits(0, 1, 1'b0);
      chk_int(1'b0);
      rd_chk(0, `IDX_ALARM, 8'h02);
      chk_int(1'b1);
      i_line.send_bits(0, 1, 1'b1);
      rd_chk(0, `IDX_ALARM, 8'h20);
      i_line.set_lvl(0, '{remote_alarm_cond: 1'b1, all_ones_alarm_cond: 1'b1,
                          frame_loss_cond: 1'b1, default: 1'b0});
      rd_chk(0, `IDX_ALARM, 8'h0D);
      rd_chk(0, `IDX_ALARM, 8'h00);
      apb(1'b0, 0, `IDX_STATE, 32'h0);
      chk(rdat, 32'h00000340);
      chk({31'h0, pready}, 32'h1);
      i_line.set_lvl(0, '0);
      rd_chk(0, `IDX_ALARM, 8'hD0);
      i_line.set_lvl(0, '{spare_code_cond: 1'b1, loop_down_cond: 1'b1,
                          loop_up_cond: 1'b1, default: 1'b0});
      rd_chk(0, `IDX_CODE, 8'h07);
      i_line.set_lvl(0, '0);
      rd_chk(0, `IDX_CODE, 8'h70);
      i_line.pulse(0, '{estore_full: 1'b1, default: 1'b0});
      chk_int(1'b0);
      rd_chk(0, `IDX_STORE, 8'hA0);
      apb(1'b1, 0, `IDX_CTRL, 32'h4);
      rd_chk(0, `IDX_STORE, 8'h02);
      rd_chk(0, `IDX_CTRL, 8'h00);
      i_line.clock_run(0, 1'b0);
      repeat (70) @(posedge pclk);
      rd_chk(0, `IDX_CODE, 8'h08);
      i_line.clock_run(0, 1'b1);
      repeat (10) @(posedge pclk);
      rd_chk(0, `IDX_CODE, 8'h80);
      $display("test t1 alarms finished");
      // Flush leftovers so stale T1 bits cannot alias E1 bits
      for (int r = 0; r < 4; r++) apb(1'b0, 0, `IDX_ALARM + 9'(r), 32'h0);
      apb(1'b1, 0, `IDX_CTRL, 32'h9);
      apb(1'b1, 0, `IDX_MASK, 32'h0000F000);
      repeat (3) i_line.pulse(0, '{fas_word_valid: 1'b1, fas_word_err: 1'b1,
                                   default: 1'b0});
      repeat (2) i_line.pulse(0, '{mf_word_valid: 1'b1, mf_word_err: 1'b1,
                                   default: 1'b0});
      for (int i = 0; i < 1000; i++) i_line.pulse(0, '{crc_word_valid: 1'b1,
                                  crc_word_err: i < 915, default: 1'b0});
      chk_int(1'b1);
      rd_chk(0, `IDX_FRAMING, 8'h70);
      apb(1'b1, 0, `IDX_MASK, 32'h0000FF00);
      i_line.pulse(0, '{sig_all_ones: 1'b1, sig_all_zeros: 1'b1,
                        crc_mf_boundary: 1'b1, align_frame: 1'b1, default: 1'b0});
      chk_int(1'b0);
      rd_chk(0, `IDX_FRAMING, 8'h0F);
      repeat (2) i_line.pulse(0, '{ts16_bit6_valid: 1'b1, ts16_bit6: 1'b1,
                                   default: 1'b0});
      rd_chk(0, `IDX_CODE, 8'h01);
      $display("test e1 events finished");
      wrap_up;
   end

   // Whole run is about 2800 cycles; ten times that is a hang
   initial begin
      repeat (30000) @(posedge pclk);
      n_errors++;
      wrap_up;
   end

endmodule : receive_alarm_event_latches_test
